/* File: dv/adcp_checker_properties.sv */
// Port checker for the converter host port block.
// Assumes pins pass two synchronising flops before the logic uses them.
`timescale 1ns/1ps
`include "adcp_defines.vh"
module adcp_checker (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Pins
    input wire interface_select,
    input wire config_mode_select,
    input wire range_pin,
    input wire rd_n,
    input wire [2:0] pair_start,
    // Derived outputs
    input wire [2:0] conv_start,
    input wire parallel_data_lines_oe,
    input wire serial_out_a,
    input wire serial_out_b,
    input wire serial_out_c,
    input wire [31:0] eff_config,
    input wire [2:0] eff_range_sel,
    // Register bus
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Tolerates one cycle of extra synchroniser delay
    a_oe_read_only: assert property (parallel_data_lines_oe |->
        (!$past(rd_n, 2) || !$past(rd_n, 3)) && !$past(interface_select, 2))
        else $error("data lines driven without a parallel read");
    a_serial_quiet: assert property ((!interface_select)[*4] |->
        !serial_out_a && !serial_out_b && !serial_out_c) else $error("serial out active");
    a_hw_upper_zero: assert property ((!config_mode_select)[*4] |->
        (eff_config & ~`ADCP_HW_MASK) == 32'h00000000) else $error("hw mode bits leak");
    a_hw_range_pin: assert property ((!config_mode_select && range_pin)[*4] |->
        eff_range_sel == 3'b111) else $error("hw range not from pin");
    a_sw_range_reg: assert property (config_mode_select[*4] |->
        eff_range_sel == eff_config[28:26]) else $error("sw range not from register");
    a_sw_start_fan: assert property ((config_mode_select && !eff_config[23]
        && pair_start == 3'b001)[*4] |-> conv_start == 3'b111) else $error("sw start");
    a_hw_start_own: assert property ((!config_mode_select && pair_start == 3'b010)[*4]
        |-> conv_start == 3'b010) else $error("hw start not per pair");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0
        (s_axi_rready or ##1 $stable(s_axi_rdata))) else $error("read answer lost");
endmodule
bind adcp_host_port adcp_checker i_adcp_checker (.*);

/* File: dv/adcp_host_model.sv */
// Serial host model: frames, serial clock, control word, output capture.
// Assumes the serial clock idles high and the block shifts on its rise.
`timescale 1ns/1ps
module adcp_host_model (
    // Host driven lines
    output reg frame_sync = 1'b1,
    output reg sclk = 1'b1,
    output reg serial_in = 1'b0,
    // Block outputs
    input wire serial_out_a,
    input wire serial_out_b,
    input wire serial_out_c
);
    reg [95:0] cap_a;
    reg [95:0] cap_b;
    reg [95:0] cap_c;
    task frame(input [31:0] cmd, input integer nfall);
        integer i;
        begin
            {cap_a, cap_b, cap_c} = 288'h0;
            frame_sync = 1'b0;
            #200;
            for (i = 0; i < nfall; i = i + 1) begin
                // Past the word the released line toggles
                serial_in = (i < 32) ? cmd[31-i] : ~serial_in;
                #62.5 sclk = 1'b0;
                cap_a = {cap_a[94:0], serial_out_a};
                cap_b = {cap_b[94:0], serial_out_b};
                cap_c = {cap_c[94:0], serial_out_c};
                #62.5 sclk = 1'b1;
            end
            #100 frame_sync = 1'b1;
            serial_in = ~serial_in;
        end
    endtask
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the host port: serial, parallel and register bus.
// Assumes the host model and the checker bound to the block.
`timescale 1ns/1ps
`include "adcp_defines.vh"
module tb;
    localparam [71:0] RES = 72'ha5a_3c1_f0e_0d2_7b4_896;
    reg core_clk = 1'b0, sys_rst = 1'b1, results_valid = 1'b0;
    reg interface_select = 1'b1, width_select = 1'b0, byte_order_select = 1'b0;
    reg config_mode_select = 1'b1, range_pin = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
    reg [71:0] results = 72'h0;
    reg [2:0] pair_start = 3'b000, port_enable = 3'b111;
    reg [15:0] pdata = 16'h0000;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00;
    reg [31:0] wdata = 32'h0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire [2:0] conv_start;
    wire [15:0] pd_out;
    wire pd_oe, frame_sync, sclk, serial_in, serial_out_a, serial_out_b, serial_out_c;
    wire awready, wready, bvalid, arready, rvalid;
    wire [31:0] eff_config, rdata;
    wire [2:0] eff_range_sel;
    wire [1:0] bresp, rresp;
    integer error_cnt = 0, tests_run = 0, cycles = 0, b;
    reg [31:0] rd, cr;
    reg [1:0] rs;
    reg [15:0] w0;
    always #4 core_clk = ~core_clk;
    adcp_host_port #(.RES_BITS(12)) i_adcp_host_port (.*, .parallel_data_lines_in(pdata),
        .parallel_data_lines_out(pd_out), .parallel_data_lines_oe(pd_oe),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    adcp_host_model i_adcp_host_model (.*);
    // Result n, zero padded to a 16-bit word
    function [15:0] w(input integer n);
        w = {4'h0, RES[71-12*n -: 12]};
    endfunction
    task check(input string name, input logic [95:0] exp, input logic [95:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("unexpected %s: expected %h, seen %h", name, exp, got);
            end
        end
    endtask
    task settle;
        repeat (6) @(posedge core_clk);
    endtask
    task axi_wr(input [7:0] a, input [31:0] d);
        begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            do begin
                @(posedge core_clk);
                if (awready)
                    awvalid <= 1'b0;
                if (wready)
                    wvalid <= 1'b0;
            end while (awvalid || wvalid);
            while (bvalid !== 1'b1) @(posedge core_clk);
            // Late ready exercises the hold of the response
            bready <= 1'b1;
            @(posedge core_clk);
            bready <= 1'b0;
            check("write resp", `ADCP_RESP_OKAY, bresp);
        end
    endtask
    task axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
        begin
            araddr <= a;
            arvalid <= 1'b1;
            do @(posedge core_clk); while (arready !== 1'b1);
            arvalid <= 1'b0;
            while (rvalid !== 1'b1) @(posedge core_clk);
            rready <= 1'b1;
            @(posedge core_clk);
            rready <= 1'b0;
            d = rdata;
            r = rresp;
        end
    endtask
    task pstrobe(input wr, input [15:0] d);
        begin
            pdata <= d;
            wr_n <= ~wr;
            rd_n <= wr;
            repeat (5) @(posedge core_clk);
            wr_n <= 1'b1;
            rd_n <= 1'b1;
            repeat (5) @(posedge core_clk);
        end
    endtask
    task end_of_test;
        begin
            $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
            if (error_cnt == 0 && tests_run > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            end_of_test;
        end
    end
    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        axi_rd(`ADCP_OFF_CR, rd, rs);
        check("cr reset", `ADCP_CR_RESET, rd);
        axi_rd(8'h3c, rd, rs);
        check("unmapped resp", `ADCP_RESP_DECERR, rs);
        results <= RES;
        results_valid <= 1'b1;
        @(posedge core_clk);
        results_valid <= 1'b0;
        settle;
        $display("test reset done");
        i_adcp_host_model.frame(32'h2a0d0321, 32);
        settle;
        check("three lanes a", {w(0), w(1)}, i_adcp_host_model.cap_a);
        check("three lanes b", {w(2), w(3)}, i_adcp_host_model.cap_b);
        check("three lanes c", {w(4), w(5)}, i_adcp_host_model.cap_c);
        cr = 32'h2a050321;
        check("full serial update", cr, eff_config);
        port_enable <= 3'b011;
        settle;
        i_adcp_host_model.frame(32'hc1000000, 48);
        settle;
        check("two lanes a", {w(0), w(1), w(4)}, i_adcp_host_model.cap_a);
        check("two lanes b", {w(2), w(3), w(5)}, i_adcp_host_model.cap_b);
        check("lane c off", 0, i_adcp_host_model.cap_c);
        cr = {8'hc1, cr[23:0]};
        check("upper serial update", cr, eff_config);
        port_enable <= 3'b001;
        settle;
        i_adcp_host_model.frame(32'h42000000, 96);
        settle;
        check("one lane a", {w(0), w(1), w(2), w(3), w(4), w(5)}, i_adcp_host_model.cap_a);
        cr = {8'h42, cr[23:0]};
        check("one lane update", cr, eff_config);
        i_adcp_host_model.frame(32'hff000000, 16);
        settle;
        check("short frame", cr, eff_config);
        $display("test serial done");
        config_mode_select <= 1'b0;
        pair_start <= 3'b010;
        range_pin <= 1'b1;
        i_adcp_host_model.frame(32'h11010000, 32);
        settle;
        check("hw pins only", 0, eff_config);
        axi_wr(`ADCP_OFF_CTRL, 32'h1);
        settle;
        check("hw with register", cr & `ADCP_HW_MASK, eff_config);
        axi_rd(`ADCP_OFF_CR, rd, rs);
        check("hw write ignored", cr, rd);
        config_mode_select <= 1'b1;
        pair_start <= 3'b001;
        settle;
        check("back to sw", cr, eff_config);
        $display("test modes done");
        interface_select <= 1'b0;
        cs_n <= 1'b0;
        settle;
        pstrobe(1'b1, 16'h9604);
        cr = {8'h96, cr[23:0]};
        check("first word write", cr, eff_config);
        pstrobe(1'b1, 16'h1234);
        cr = 32'h96040234;
        check("second word write", cr, eff_config);
        axi_rd(`ADCP_OFF_CR, rd, rs);
        check("cr after parallel", cr, rd);
        pstrobe(1'b0, 16'h0000);
        check("word read a0", w(0), pd_out);
        pstrobe(1'b0, 16'h0000);
        check("word read a1", w(1), pd_out);
        width_select <= 1'b1;
        w0 = w(0);
        for (b = 0; b < 2; b = b + 1) begin
            byte_order_select <= b[0];
            results_valid <= 1'b1;
            @(posedge core_clk);
            results_valid <= 1'b0;
            settle;
            pstrobe(1'b0, 16'h0000);
            check("first byte", {b ? w0[15:8] : w0[7:0], 8'h00}, pd_out);
            pstrobe(1'b0, 16'h0000);
            check("second byte", {b ? w0[7:0] : w0[15:8], 8'h00}, pd_out);
        end
        cs_n <= 1'b1;
        $display("test parallel done");
        end_of_test;
    end
endmodule

/* File: src/adcp_defines.vh */
// Constants for the converter host port and configuration block.
// Included by the host port design file, the bench and the checker, not by the shift lane or the host model; holds definitions only.
`ifndef ADCP_DEFINES_VH
`define ADCP_DEFINES_VH

// AXI4-Lite register byte offsets
`define ADCP_OFF_CTRL 8'h00
`define ADCP_OFF_CR 8'h04
`define ADCP_OFF_STATUS 8'h08

// Reset values
`define ADCP_CTRL_RESET 32'h00000000
`define ADCP_CR_RESET 32'h000003ff

// Control register field positions
`define ADCP_BIT_FULL_EN 16
`define ADCP_BIT_READ_EN 17
`define ADCP_BIT_SEQ 23
`define ADCP_RANGE_LSB 26

// Bits that stay active in hardware mode, and bits that can be written (the rest always read zero)
`define ADCP_HW_MASK 32'h007ce3ff
`define ADCP_CR_WMASK 32'hfff7efff

// Smallest reference code that keeps the reference output at or above 0.5 V
`define ADCP_REFDAC_MIN 10'h0cc

// Serial update commits on this falling serial clock edge
`define ADCP_SER_COMMIT_EDGE 7'h20

// AXI responses
`define ADCP_RESP_OKAY 2'b00
`define ADCP_RESP_DECERR 2'b11

`endif

/* File: src/adcp_host_port.v */
// Host port and configuration logic of a six-channel sampling converter:
// parallel port, serial port, control register and mode handling.
// Assumes results arrive from the converter core on core_clk; all pins are
// asynchronous and pass two flip-flops; software reaches it over AXI4-Lite.
//
// Functional notes
// - Parallel port is 16 bits when width select low, else 8 bits.
// - In byte mode byte order pin picks low or high byte first on DB[15:8].
// - Interface select high enables serial; transfers start at frame sync fall.
// - Serial data MSB first, changing on rising serial clock edges.
// - Narrower results go out as 16-bit words with leading zeros.
// - Serial input bit captured on falling serial clock edge.
// - Three outputs: each sends its pair channel 0 then channel 1.
// - Two outputs: A sends A0 A1 C0, B sends B0 B1 C1.
// - One output: A sends A0 A1 B0 B1 C0 C1.
// - Hardware mode follows pins, optionally control bits 22:18, 15:13, 9:0.
// - Hardware mode with serial port ignores control bits 31:24.
// - Software mode uses control register only; configuration pins ignored.
// - Software mode starts all pairs from pair A start, unless sequential.
// - Control register survives a trip to hardware mode and back.
// - A single parallel write updates only control bits 31:24.
// - Word mode holds bits 23:16 from first write until the second.
// - Updates apply at write strobe rise or 32nd falling serial edge.
// - Reference code sits in control bits 9:0.
`timescale 1ns/1ps
`include "adcp_defines.vh"
module adcp_host_port #(
    parameter RES_BITS = 16
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Converter core side
    input wire [6*RES_BITS-1:0] results,
    input wire results_valid,
    // Mode pins
    input wire interface_select,
    input wire width_select,
    input wire byte_order_select,
    input wire config_mode_select,
    input wire range_pin,
    // Conversion start pins and resulting starts
    input wire [2:0] pair_start,
    output wire [2:0] conv_start,
    // Parallel port
    input wire cs_n,
    input wire rd_n,
    input wire wr_n,
    input wire [15:0] parallel_data_lines_in,
    output wire [15:0] parallel_data_lines_out,
    output wire parallel_data_lines_oe,
    // Serial port
    input wire frame_sync,
    input wire sclk,
    input wire serial_in,
    input wire [2:0] port_enable,
    output wire serial_out_a,
    output wire serial_out_b,
    output wire serial_out_c,
    // Effective configuration
    output wire [31:0] eff_config,
    output wire [2:0] eff_range_sel,
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);
    localparam NSYNC = 33;

    // Two-stage synchroniser; third stage only for edge detection
    wire [NSYNC-1:0] pins_raw;
    reg [NSYNC-1:0] sync1_reg;
    reg [NSYNC-1:0] sync2_reg;
    reg [NSYNC-1:0] sync3_reg;
    assign pins_raw = {parallel_data_lines_in, port_enable, pair_start, serial_in,
                       sclk, frame_sync, wr_n, rd_n, cs_n, range_pin,
                       config_mode_select, byte_order_select, width_select,
                       interface_select};
    always @(posedge core_clk) begin
        if (sys_rst) begin
            sync1_reg <= {NSYNC{1'b1}};
            sync2_reg <= {NSYNC{1'b1}};
            sync3_reg <= {NSYNC{1'b1}};
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    wire ser_mode = sync2_reg[0];
    wire byte_mode = sync2_reg[1];
    wire hi_first = sync2_reg[2];
    wire sw_mode = sync2_reg[3];
    wire range_s = sync2_reg[4];
    wire cs_s = sync2_reg[5];
    wire rd_s = sync2_reg[6];
    wire wr_s = sync2_reg[7];
    wire sin_s = sync2_reg[10];
    wire [2:0] start_s = sync2_reg[13:11];
    wire [2:0] sel_s = sync2_reg[16:14];
    wire [15:0] db_s = sync2_reg[32:17];
    wire fs_fall = sync3_reg[8] & ~sync2_reg[8];
    wire fs_rise = ~sync3_reg[8] & sync2_reg[8];
    wire sclk_rise = ~sync3_reg[9] & sync2_reg[9];
    wire sclk_fall = sync3_reg[9] & ~sync2_reg[9];
    wire rd_fall = sync3_reg[6] & ~rd_s;
    wire rd_rise = ~sync3_reg[6] & rd_s;
    wire wr_rise = ~sync3_reg[7] & wr_s;

    // Latched results, zero-extended to 16 bits
    reg [6*RES_BITS-1:0] res_reg;
    wire [95:0] words;
    always @(posedge core_clk) begin
        if (sys_rst) begin
            res_reg <= {6*RES_BITS{1'b0}};
        end else if (results_valid) begin
            res_reg <= results;
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_ext
            wire [RES_BITS+15:0] ext;
            assign ext = {16'h0000, res_reg[(5-gi)*RES_BITS +: RES_BITS]};
            assign words[(5-gi)*16 +: 16] = ext[15:0];
        end
    endgenerate
    wire [15:0] w_a0 = words[95:80];
    wire [15:0] w_a1 = words[79:64];
    wire [15:0] w_b0 = words[63:48];
    wire [15:0] w_b1 = words[47:32];
    wire [15:0] w_c0 = words[31:16];
    wire [15:0] w_c1 = words[15:0];

    // Control register and parallel write sequencing
    reg [31:0] cr_reg;
    reg [31:0] cr_next;
    reg [23:0] pend_reg;
    reg [23:0] pend_next;
    reg [1:0] wcnt_reg;
    reg [1:0] wcnt_next;
    reg [6:0] fcnt_reg;
    reg [31:0] sin_reg;
    reg frame_reg;
    wire [31:0] ser_word = {sin_reg[30:0], sin_s};
    wire par_wr = sw_mode & ~ser_mode & ~cs_s & wr_rise;
    wire ser_commit = sw_mode & ser_mode & frame_reg & sclk_fall &
                      (fcnt_reg == `ADCP_SER_COMMIT_EDGE - 7'h01);

    always @* begin
        cr_next = cr_reg;
        pend_next = pend_reg;
        wcnt_next = wcnt_reg;
        if (cs_s) begin
            wcnt_next = 2'h0;
        end
        if (par_wr) begin
            wcnt_next = wcnt_reg + 2'h1;
            if (wcnt_reg == 2'h0) begin
                cr_next[31:24] = db_s[15:8];
                pend_next[23:16] = db_s[7:0];
            end else if (!byte_mode) begin
                cr_next[23:0] = {pend_reg[23:16], db_s};
                wcnt_next = 2'h0;
            end else if (wcnt_reg == 2'h1) begin
                pend_next[23:16] = db_s[15:8];
            end else if (wcnt_reg == 2'h2) begin
                pend_next[15:8] = db_s[15:8];
            end else begin
                cr_next[23:0] = {pend_reg[23:8], db_s[15:8]};
            end
        end
        if (ser_commit) begin
            cr_next[31:24] = ser_word[31:24];
            if (ser_word[`ADCP_BIT_FULL_EN]) begin
                cr_next[23:0] = ser_word[23:0];
            end
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            cr_reg <= `ADCP_CR_RESET;
            pend_reg <= 24'h000000;
            wcnt_reg <= 2'h0;
        end else begin
            cr_reg <= cr_next & `ADCP_CR_WMASK;
            pend_reg <= pend_next;
            wcnt_reg <= wcnt_next;
        end
    end

    // Parallel readout
    reg [2:0] ridx_reg;
    reg bph_reg;
    reg [15:0] db_out_reg;
    reg [15:0] cur_word;
    always @* begin
        case (ridx_reg)
            3'h0: cur_word = w_a0;
            3'h1: cur_word = w_a1;
            3'h2: cur_word = w_b0;
            3'h3: cur_word = w_b1;
            3'h4: cur_word = w_c0;
            3'h5: cur_word = w_c1;
            default: cur_word = 16'h0000;
        endcase
    end
    always @(posedge core_clk) begin
        if (sys_rst) begin
            ridx_reg <= 3'h0;
            bph_reg <= 1'b0;
            db_out_reg <= 16'h0000;
        end else if (results_valid) begin
            ridx_reg <= 3'h0;
            bph_reg <= 1'b0;
        end else if (!ser_mode && !cs_s) begin
            if (rd_fall && !byte_mode) begin
                db_out_reg <= cur_word;
            end else if (rd_fall) begin
                // Byte lanes only on the upper lines
                if (bph_reg ^ hi_first) begin
                    db_out_reg <= {cur_word[15:8], 8'h00};
                end else begin
                    db_out_reg <= {cur_word[7:0], 8'h00};
                end
            end
            if (rd_rise) begin
                bph_reg <= byte_mode & ~bph_reg;
                if ((!byte_mode || bph_reg) && ridx_reg != 3'h5) begin
                    ridx_reg <= ridx_reg + 3'h1;
                end
            end
        end
    end
    assign parallel_data_lines_out = db_out_reg;
    assign parallel_data_lines_oe = ~ser_mode & ~cs_s & ~rd_s;

    // Serial frame control
    always @(posedge core_clk) begin
        if (sys_rst) begin
            frame_reg <= 1'b0;
            fcnt_reg <= 7'h00;
            sin_reg <= 32'h00000000;
        end else if (!ser_mode || fs_rise) begin
            frame_reg <= 1'b0;
        end else if (fs_fall) begin
            frame_reg <= 1'b1;
            fcnt_reg <= 7'h00;
        end else if (frame_reg && sclk_fall) begin
            sin_reg <= ser_word;
            if (fcnt_reg != 7'h7f) begin
                fcnt_reg <= fcnt_reg + 7'h01;
            end
        end
    end

    wire lane_load = ser_mode & fs_fall;
    // First bit is already out at frame start, so shift after the first fall
    wire lane_shift = frame_reg & sclk_rise & (fcnt_reg != 7'h00);
    wire show_cr = cr_reg[`ADCP_BIT_READ_EN];
    reg [95:0] ld_a;
    reg [47:0] ld_b;
    reg [31:0] ld_c;
    always @* begin
        ld_a = {w_a0, w_a1, w_b0, w_b1, w_c0, w_c1};
        ld_b = 48'h000000000000;
        ld_c = 32'h00000000;
        if (sel_s == 3'b111) begin
            ld_a = {w_a0, w_a1, 64'h0000000000000000};
            ld_b = {w_b0, w_b1, 16'h0000};
            ld_c = {w_c0, w_c1};
        end else if (sel_s[1]) begin
            ld_a = {w_a0, w_a1, w_c0, 48'h000000000000};
            ld_b = {w_b0, w_b1, w_c1};
        end
        if (show_cr) begin
            ld_a = {cr_reg, 64'h0000000000000000};
            ld_b = {cr_reg, 16'h0000};
            ld_c = cr_reg;
        end
    end

    wire lane_a;
    wire lane_b;
    wire lane_c;
    adcp_shift_lane #(.WIDTH(96)) u_lane_a (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(lane_load),
        .load_value(ld_a),
        .shift(lane_shift),
        .bit_out(lane_a)
    );
    adcp_shift_lane #(.WIDTH(48)) u_lane_b (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(lane_load),
        .load_value(ld_b),
        .shift(lane_shift),
        .bit_out(lane_b)
    );
    adcp_shift_lane #(.WIDTH(32)) u_lane_c (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(lane_load),
        .load_value(ld_c),
        .shift(lane_shift),
        .bit_out(lane_c)
    );
    assign serial_out_a = ser_mode & sel_s[0] & lane_a;
    assign serial_out_b = ser_mode & sel_s[1] & lane_b;
    assign serial_out_c = ser_mode & sel_s[2] & lane_c;

    // Effective configuration and conversion starts
    reg [31:0] ctrl_reg;
    wire hw_use_cr = ctrl_reg[0];
    // Hardware mode never sees the upper byte, so 31:24 are masked on both ports
    assign eff_config = sw_mode ? cr_reg :
                        (hw_use_cr ? (cr_reg & `ADCP_HW_MASK) : 32'h00000000);
    assign eff_range_sel = sw_mode ? cr_reg[`ADCP_RANGE_LSB +: 3] : {3{range_s}};
    assign conv_start = (sw_mode && !cr_reg[`ADCP_BIT_SEQ]) ?
                        {3{start_s[0]}} : start_s;
    wire refdac_low = cr_reg[9:0] < `ADCP_REFDAC_MIN;

    // AXI4-Lite slave
    reg aw_ok_reg;
    reg w_ok_reg;
    reg [7:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    reg bvalid_reg;
    reg [1:0] bresp_reg;
    reg rvalid_reg;
    reg [1:0] rresp_reg;
    reg [31:0] rdata_reg;
    integer bi;
    assign s_axi_awready = ~aw_ok_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_ok_reg & ~bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            aw_ok_reg <= 1'b0;
            w_ok_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `ADCP_RESP_OKAY;
            ctrl_reg <= `ADCP_CTRL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (aw_ok_reg && w_ok_reg) begin
                aw_ok_reg <= 1'b0;
                w_ok_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= `ADCP_RESP_DECERR;
                if (awaddr_reg[7:2] == `ADCP_OFF_CTRL >> 2) begin
                    bresp_reg <= `ADCP_RESP_OKAY;
                    for (bi = 0; bi < 4; bi = bi + 1) begin
                        if (wstrb_reg[bi]) begin
                            ctrl_reg[bi*8 +: 8] <= wdata_reg[bi*8 +: 8];
                        end
                    end
                end else if (awaddr_reg[7:2] == `ADCP_OFF_CR >> 2 ||
                             awaddr_reg[7:2] == `ADCP_OFF_STATUS >> 2) begin
                    // Read-only registers ignore writes
                    bresp_reg <= `ADCP_RESP_OKAY;
                end
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `ADCP_RESP_OKAY;
            rdata_reg <= 32'h00000000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= `ADCP_RESP_OKAY;
            case (s_axi_araddr[7:2])
                `ADCP_OFF_CTRL >> 2: rdata_reg <= {31'h00000000, ctrl_reg[0]};
                `ADCP_OFF_CR >> 2: rdata_reg <= cr_reg;
                `ADCP_OFF_STATUS >> 2: rdata_reg <= {24'h000000, refdac_low, frame_reg,
                                                     wcnt_reg, byte_mode, ser_mode,
                                                     sw_mode, 1'b0};
                default: begin
                    rdata_reg <= 32'h00000000;
                    rresp_reg <= `ADCP_RESP_DECERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
endmodule

/* File: src/adcp_shift_lane.v */
// One serial output lane: parallel load, shift toward the MSB.
// Assumes load and shift come from logic on core_clk; load wins.
`timescale 1ns/1ps
module adcp_shift_lane #(
    parameter WIDTH = 32
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Control
    input wire load,
    input wire [WIDTH-1:0] load_value,
    input wire shift,
    // Serial bit, MSB first
    output wire bit_out
);
    reg [WIDTH-1:0] sr_reg;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            sr_reg <= {WIDTH{1'b0}};
        end else if (load) begin
            sr_reg <= load_value;
        end else if (shift) begin
            sr_reg <= {sr_reg[WIDTH-2:0], 1'b0};
        end
    end

    assign bit_out = sr_reg[WIDTH-1];
endmodule
